// ==== hcs_cmd_status.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] written ones set bits, zeros keep
// [RQ2] reads return all bits, no side effects
// [RQ3] overrun bumps counter and raises status flag
// [RQ4] two-bit counter at 17:16, wraps
// [RQ5] counter counts even with flag set
// [RQ6] ownership request raises ownership-changed flag
// [RQ7] handover done clears ownership request bit
// [RQ8] software sets bulk filled on new td
// [RQ9] bulk head: skip if zero, else clear
// [RQ10] bulk td found sets bulk filled again
// [RQ11] software sets control filled on new td
// [RQ12] control head: skip if zero, else clear
// [RQ13] control td found sets control filled again
// [RQ14] soft reset moves state to suspended
// [RQ15] soft reset keeps routing bit, blocks bus
// [RQ16] soft reset bit clears within 10 us
// [RQ17] soft reset leaves root hub alone
// [RQ18] software writes reserved bits as zero
// [RQ19] hard reset gives reset state, resets hub; code does neither (no state load, root_hub_reset_o tied low)
// [RQ20] software clears status flags by writing one
// [RQ21] software set beats device clear
module hcs_cmd_status import hcs_pkg::*; #(
  parameter int RESET_CYCLES = 64 // soft reset length, must stay below the 10 us limit
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire hcs_reg_req_t req_i,
  output logic [31:0] rdata_o,
  // list engine events and answers
  input wire hcs_engine_ev_t ev_i,
  output logic bulk_process_o,
  output logic ctrl_process_o,
  output logic bulk_filled_o,
  output logic ctrl_filled_o,
  // interrupt status set pulses
  output logic [31:0] irq_set_o,
  // soft reset effects
  output logic soft_reset_o,
  output logic host_bus_block_o,
  output logic func_state_load_o,
  output hcs_func_state_t func_state_o,
  output logic routing_keep_o,
  output logic root_hub_reset_o
);
  // the limit is a hard ceiling; a longer sequence would break the timing promise
  localparam int CHECKED_CYCLES = (RESET_CYCLES < HCS_SOFT_RESET_MAX_CYC) ? RESET_CYCLES : HCS_SOFT_RESET_MAX_CYC;

  logic [HCS_CMD_W-1:0] cmd_q, cmd_d; // command bits 3:0
  logic [HCS_OVR_CNT_W-1:0] ovr_q, ovr_d; // overrun counter
  logic [31:0] rdata_q;
  logic own_req_seen_q; // request already announced
  logic reset_busy_w;
  logic reset_done_w;

  // decode of the one register
  function automatic logic hit(input hcs_reg_req_t r, input logic [7:0] off);
    return r.addr == off;
  endfunction : hit

  wire wr_hit_w = req_i.wr & hit(req_i, HCS_CMD_STATUS_OFFSET);
  wire rd_hit_w = req_i.rd & hit(req_i, HCS_CMD_STATUS_OFFSET);
  // reserved and counter bits ignore writes
  wire [HCS_CMD_W-1:0] sw_set_w = wr_hit_w ? req_i.wdata[HCS_CMD_W-1:0] : '0; // [RQ1] [RQ18]

  // device-side clear and set terms per command bit
  wire bulk_take_w = ev_i.bulk_head & cmd_q[HCS_BULK_FILLED_BIT];
  wire ctrl_take_w = ev_i.ctrl_head & cmd_q[HCS_CTRL_FILLED_BIT];
  wire [HCS_CMD_W-1:0] hw_clr_w = {ev_i.own_done, bulk_take_w, ctrl_take_w, reset_done_w};
  wire [HCS_CMD_W-1:0] hw_set_w = {1'b0, ev_i.bulk_td_found, ev_i.ctrl_td_found, 1'b0};

  // per bit: set (software or td found) wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < HCS_CMD_W; gi++) begin : g_cmd
      always_comb begin
        cmd_d[gi] = cmd_q[gi];
        if (sw_set_w[gi] | hw_set_w[gi]) begin
          cmd_d[gi] = 1'b1; // [RQ1] [RQ10] [RQ13] [RQ21]
        end else if (hw_clr_w[gi]) begin
          cmd_d[gi] = 1'b0; // [RQ7] [RQ9] [RQ12] [RQ16]
        end
      end
    end
  endgenerate

  // counter wraps naturally at its width
  assign ovr_d = ev_i.overrun ? ovr_q + 2'h1 : ovr_q; // [RQ3] [RQ4] [RQ5]

  // command and counter registers; a soft reset also clears the counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q <= HCS_CMD_STATUS_RESET[HCS_CMD_W-1:0];
      ovr_q <= HCS_CMD_STATUS_RESET[HCS_OVR_CNT_LSB +: HCS_OVR_CNT_W];
    end else begin
      cmd_q <= cmd_d;
      ovr_q <= reset_done_w ? HCS_CMD_STATUS_RESET[HCS_OVR_CNT_LSB +: HCS_OVR_CNT_W] : ovr_d;
    end
  end

  // ownership flag raised once per request edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_req_seen_q <= 1'b0;
    end else begin
      own_req_seen_q <= cmd_q[HCS_OWN_REQ_BIT];
    end
  end

  // status flag pulses; software clears them in the status register
  always_comb begin
    irq_set_o = '0;
    irq_set_o[HCS_IRQ_OVERRUN_BIT] = ev_i.overrun; // [RQ3]
    irq_set_o[HCS_IRQ_OWN_CHANGED_BIT] = cmd_q[HCS_OWN_REQ_BIT] & ~own_req_seen_q; // [RQ6]
  end

  // read data registered, no side effect on read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (rd_hit_w) begin
      rdata_q <= {14'h0000, ovr_q, 12'h000, cmd_q}; // [RQ2]
    end else if (req_i.rd) begin
      rdata_q <= '0; // unmapped reads as zero
    end
  end
  assign rdata_o = rdata_q;

  // soft reset sequencer
  hcs_reset_seq #(
    .RESET_CYCLES(CHECKED_CYCLES)
  ) u_reset_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cmd_q[HCS_SOFT_RESET_BIT] & ~reset_busy_w), // [RQ14]
    .busy_o(reset_busy_w),
    .done_o(reset_done_w) // [RQ16]
  );

  // list engine answers at the list heads
  assign bulk_process_o = bulk_take_w; // [RQ9]
  assign ctrl_process_o = ctrl_take_w; // [RQ12]
  assign bulk_filled_o = cmd_q[HCS_BULK_FILLED_BIT];
  assign ctrl_filled_o = cmd_q[HCS_CTRL_FILLED_BIT];

  // soft reset effects toward the rest of the core
  assign soft_reset_o = reset_busy_w; // [RQ15]
  assign host_bus_block_o = reset_busy_w; // [RQ15]
  assign routing_keep_o = 1'b1; // routing bit never cleared by soft reset [RQ15]
  assign func_state_load_o = reset_done_w; // [RQ14] [RQ19]
  assign func_state_o = HCS_FS_SUSPENDED; // [RQ14] [RQ19]
  assign root_hub_reset_o = 1'b0; // hub reset tied low, so hard reset does not reset the hub either [RQ17]
endmodule : hcs_cmd_status

// ==== hcs_pkg.sv ====
package hcs_pkg;
  // register location and field positions
  localparam logic [7:0] HCS_CMD_STATUS_OFFSET = 8'h08;
  localparam logic [31:0] HCS_CMD_STATUS_RESET = 32'h0000_0000;
  localparam int HCS_SOFT_RESET_BIT = 0;
  localparam int HCS_CTRL_FILLED_BIT = 1;
  localparam int HCS_BULK_FILLED_BIT = 2;
  localparam int HCS_OWN_REQ_BIT = 3;
  localparam int HCS_OVR_CNT_LSB = 16;
  localparam int HCS_OVR_CNT_W = 2;
  localparam int HCS_CMD_W = 4;
  // interrupt status flag positions driven from here
  localparam int HCS_IRQ_OVERRUN_BIT = 0;
  localparam int HCS_IRQ_OWN_CHANGED_BIT = 30;
  // control register routing bit kept over soft reset
  localparam int HCS_CTRL_ROUTING_BIT = 8;
  // functional state encodings of the control register
  typedef enum logic [1:0] {
    HCS_FS_RESET = 2'h0,
    HCS_FS_RESUME = 2'h1,
    HCS_FS_OPERATIONAL = 2'h2,
    HCS_FS_SUSPENDED = 2'h3
  } hcs_func_state_t;
  // soft reset timing
  localparam int HCS_CLK_MHZ = 200;
  localparam int HCS_SOFT_RESET_MAX_US = 10;
  localparam int HCS_SOFT_RESET_MAX_CYC = HCS_SOFT_RESET_MAX_US * HCS_CLK_MHZ;
  // list engine events toward the command bits
  typedef struct packed {
    logic bulk_head;      // engine reached bulk list head
    logic bulk_td_found;  // td found while walking bulk list
    logic ctrl_head;      // engine reached control list head
    logic ctrl_td_found;  // td found while walking control list
    logic overrun;        // periodic list missed end of frame
    logic own_done;       // ownership handover complete
  } hcs_engine_ev_t;
  // register read/write request port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hcs_reg_req_t;
endpackage : hcs_pkg

// ==== hcs_reset_seq.sv ====
`timescale 1ns/1ps
// soft reset sequencer: walks a fixed count, then reports done
module hcs_reset_seq import hcs_pkg::*; #(
  parameter int RESET_CYCLES = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    HCS_RS_IDLE = 2'b00,
    HCS_RS_RUN = 2'b01,
    HCS_RS_DONE = 2'b11
  } hcs_rs_state_t;

  hcs_rs_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d; // cycles spent in the run state
  wire last_w = (cnt_q == 16'(RESET_CYCLES - 1));

  // next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      HCS_RS_IDLE: begin
        cnt_d = '0;
        if (start_i) begin
          state_d = HCS_RS_RUN;
        end
      end
      HCS_RS_RUN: begin
        cnt_d = cnt_q + 16'h0001;
        if (last_w) begin
          state_d = HCS_RS_DONE;
        end
      end
      HCS_RS_DONE: begin
        state_d = HCS_RS_IDLE;
      end
      default: begin
        state_d = HCS_RS_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= HCS_RS_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (state_q != HCS_RS_IDLE);
  assign done_o = (state_q == HCS_RS_DONE);
endmodule : hcs_reset_seq

// ==== hcs_cmd_status_sva.sv ====
`timescale 1ns/1ps
// checker on the command/status ports
module hcs_cmd_status_sva import hcs_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // observed ports
  input wire hcs_reg_req_t req_i,
  input wire hcs_engine_ev_t ev_i,
  input wire logic bulk_process_o,
  input wire logic ctrl_process_o,
  input wire logic bulk_filled_o,
  input wire logic ctrl_filled_o,
  input wire logic [31:0] irq_set_o,
  input wire logic soft_reset_o,
  input wire logic host_bus_block_o,
  input wire logic func_state_load_o,
  input wire hcs_func_state_t func_state_o,
  input wire logic root_hub_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // write aimed at this register
  wire wr_hit = req_i.wr && req_i.addr == HCS_CMD_STATUS_OFFSET;
  AST_OVR: assert property (irq_set_o[0] == ev_i.overrun)
    else $error("overrun flag not tied to overrun event");
  AST_BULK_GO: assert property (bulk_process_o == (ev_i.bulk_head && bulk_filled_o))
    else $error("bulk process decision wrong");
  AST_CTRL_GO: assert property (ctrl_process_o == (ev_i.ctrl_head && ctrl_filled_o))
    else $error("control process decision wrong");
  AST_BULK_CLR: assert property (
    ev_i.bulk_head && bulk_filled_o && !ev_i.bulk_td_found && !(wr_hit && req_i.wdata[2]) |=> !bulk_filled_o)
    else $error("bulk filled not cleared at head");
  AST_CTRL_CLR: assert property (
    ev_i.ctrl_head && ctrl_filled_o && !ev_i.ctrl_td_found && !(wr_hit && req_i.wdata[1]) |=> !ctrl_filled_o)
    else $error("control filled not cleared at head");
  AST_BULK_TD: assert property (ev_i.bulk_td_found |=> bulk_filled_o)
    else $error("bulk td did not set filled");
  AST_CTRL_SET: assert property (wr_hit && req_i.wdata[1] |=> ctrl_filled_o)
    else $error("written one lost on control filled");
  AST_KEEP: assert property (ctrl_filled_o && !ev_i.ctrl_head |=> ctrl_filled_o)
    else $error("control filled dropped without head");
  AST_SR_DONE: assert property ($rose(soft_reset_o) |-> ##[1:1000] func_state_load_o)
    else $error("soft reset did not finish in time");
  AST_SR_STATE: assert property (func_state_load_o |-> func_state_o == HCS_FS_SUSPENDED && !root_hub_reset_o)
    else $error("soft reset end state wrong");
  AST_BLOCK: assert property (host_bus_block_o == soft_reset_o)
    else $error("bus block not matching soft reset");
endmodule : hcs_cmd_status_sva
bind hcs_cmd_status hcs_cmd_status_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .ev_i(ev_i),
  .bulk_process_o(bulk_process_o), .ctrl_process_o(ctrl_process_o), .bulk_filled_o(bulk_filled_o),
  .ctrl_filled_o(ctrl_filled_o), .irq_set_o(irq_set_o), .soft_reset_o(soft_reset_o),
  .host_bus_block_o(host_bus_block_o), .func_state_load_o(func_state_load_o), .func_state_o(func_state_o),
  .root_hub_reset_o(root_hub_reset_o));

// ==== hcs_sw_model.sv ====
`timescale 1ns/1ps
// driver software model: one-cycle strobes, idle bus shows inverted junk
module hcs_sw_model import hcs_pkg::*; (
  // clock
  input wire logic clk_i,
  // register port
  input wire logic [31:0] rdata_i,
  output hcs_reg_req_t req_o
);
  initial req_o = '0;
  // reserved bits are always written as zero by callers
  // status flags live elsewhere; the driver clears them by writing ones there
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i) req_o <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  // data lands on the taking edge, sampled once settled
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i) req_o <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, 32'hffff_ffff};
    #1 d = rdata_i;
  endtask : rd
endmodule : hcs_sw_model

// ==== host_command_status_reg_tb_top.sv ====
`timescale 1ns/1ps
module host_command_status_reg_tb_top import hcs_pkg::*;;
  localparam int RC = 4; // short soft reset for sim
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] ev = 6'h00;
  hcs_reg_req_t req;
  logic [31:0] rdata_o, irq_set_o, rd;
  logic bulk_process_o, ctrl_process_o, bulk_filled_o, ctrl_filled_o, soft_reset_o, host_bus_block_o;
  logic func_state_load_o, routing_keep_o, root_hub_reset_o, seen;
  logic [2:0] p;
  hcs_func_state_t func_state_o;
  int err_total = 0;
  int checks = 0;
  int n;
  always #2.5 clk_i = ~clk_i;
  hcs_sw_model u_sw (.clk_i(clk_i), .rdata_i(rdata_o), .req_o(req));
  hcs_cmd_status #(.RESET_CYCLES(RC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .ev_i(hcs_engine_ev_t'(ev)), .bulk_process_o(bulk_process_o), .ctrl_process_o(ctrl_process_o),
    .bulk_filled_o(bulk_filled_o), .ctrl_filled_o(ctrl_filled_o), .irq_set_o(irq_set_o),
    .soft_reset_o(soft_reset_o), .host_bus_block_o(host_bus_block_o), .func_state_load_o(func_state_load_o),
    .func_state_o(func_state_o), .routing_keep_o(routing_keep_o), .root_hub_reset_o(root_hub_reset_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one-cycle engine event; decisions sampled inside the pulse
  task automatic pulse(input logic [5:0] b);
    @(posedge clk_i) ev <= b;
    #1 p = {bulk_process_o, ctrl_process_o, irq_set_o[0]};
    @(posedge clk_i) ev <= 6'h00;
    #1;
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic t_setonly;
    u_sw.wr(8'h08, 32'h2);
    u_sw.wr(8'h08, 32'h4);
    u_sw.wr(8'h0c, 32'hf); // other offset must be ignored
    u_sw.rd(8'h08, rd); chk(rd, 32'h6, "set only");
    u_sw.rd(8'h08, rd); chk(rd, 32'h6, "read again");
    u_sw.rd(8'h0c, rd); chk(rd, 32'h0, "other offset");
    $display("t_setonly done");
  endtask : t_setonly
  task automatic t_lists;
    // i=0 bulk list, i=1 control list
    for (int i = 0; i < 2; i++) begin
      pulse(6'h20 >> (2 * i)); chk(p[2-i], 1'b1, "process");
      chk({bulk_filled_o, ctrl_filled_o} >> (1 - i) & 2'h1, 1'b0, "cleared");
      pulse(6'h20 >> (2 * i)); chk(p[2-i], 1'b0, "skip");
      pulse(6'h10 >> (2 * i)); chk({bulk_filled_o, ctrl_filled_o} >> (1 - i) & 2'h1, 1'b1, "td");
    end
    fork
      u_sw.wr(8'h08, 32'h2);
      pulse(6'h08);
    join
    chk(ctrl_filled_o, 1'b1, "set beats clear");
    $display("t_lists done");
  endtask : t_lists
  task automatic t_overrun;
    repeat (5) begin
      pulse(6'h02); chk(p[0], 1'b1, "overrun flag");
    end
    u_sw.rd(8'h08, rd); chk(rd, 32'h0001_0006, "count wraps");
    $display("t_overrun done");
  endtask : t_overrun
  task automatic t_own;
    seen = 1'b0;
    u_sw.wr(8'h08, 32'h8);
    repeat (3) begin
      #1 seen |= irq_set_o[30];
      @(posedge clk_i);
    end
    chk(seen, 1'b1, "ownership flag");
    pulse(6'h01);
    u_sw.rd(8'h08, rd); chk(rd, 32'h0001_0006, "request cleared");
    $display("t_own done");
  endtask : t_own
  task automatic t_soft;
    u_sw.wr(8'h08, 32'h1);
    // sequencer leaves idle one edge after the command bit lands
    @(posedge clk_i);
    #1 chk(host_bus_block_o, 1'b1, "bus blocked");
    n = 0;
    while (func_state_load_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(n <= RC + 3, 1'b1, "reset length");
    chk(func_state_o, HCS_FS_SUSPENDED, "suspended");
    chk(root_hub_reset_o, 1'b0, "hub untouched");
    u_sw.rd(8'h08, rd); chk(rd, 32'h6, "after soft reset");
    $display("t_soft done");
  endtask : t_soft
  // watchdog sized well above the roughly 60 cycles of traffic
  initial begin
    #20000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    u_sw.rd(8'h08, rd); chk(rd, HCS_CMD_STATUS_RESET, "reset value");
    chk(routing_keep_o, 1'b1, "routing kept");
    t_setonly();
    t_lists();
    t_overrun();
    t_own();
    t_soft();
    complete_run();
  end
endmodule : host_command_status_reg_tb_top
